// File: dv/tb.sv
// Self-checking testbench of the timer compare unit.
`timescale 1ns/1ps

module tb;
    // ****************************************************************
    // Signals and instances.
    // ****************************************************************
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ext_count_pin = 1'b0;
    logic        global_irq_enable = 1'b0;
    logic        service_en = 1'b0;
    logic        ovf_ack, cmp_ack, ovf_irq, cmp_irq, compare_output;
    logic [31:0] q;
    int          miscompares = 0;
    int          total_checks = 0;
    typedef struct { logic [4:0] a; logic [7:0] d; logic [7:0] e; } tcu_row_t;
    tcu_row_t rows [8] = '{'{5'h04, 8'hA5, 8'hA5}, '{5'h08, 8'h3C, 8'h3C},
        '{5'h10, 8'h03, 8'h03}, '{5'h10, 8'h00, 8'h00}, '{5'h00, 8'h60, 8'h60},
        '{5'h00, 8'h00, 8'h00}, '{5'h18, 8'hFF, 8'h00}, '{5'h0C, 8'h03, 8'h00}};
    int rng [2][4] = '{'{1, 20, 19, 25}, '{2, 80, 9, 12}};

    always #2.5 core_clk = ~core_clk;

    tcu_timer i_tcu_timer (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_count_pin(ext_count_pin), .global_irq_enable(global_irq_enable),
        .overflow_irq_ack(ovf_ack), .compare_irq_ack(cmp_ack), .overflow_irq(ovf_irq),
        .compare_irq(cmp_irq), .compare_output(compare_output));
    tcu_cpu_model i_tcu_cpu_model (.core_clk(core_clk), .resetn(resetn),
        .service_en(service_en), .overflow_irq(ovf_irq), .compare_irq(cmp_irq),
        .overflow_irq_ack(ovf_ack), .compare_irq_ack(cmp_ack));

    // ****************************************************************
    // Tasks.
    // ****************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Compares a value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // One Avalon cycle; the request stands until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int   n;
        logic w;
        n = 0;
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        // Sample what the next rising edge will see.
        do begin
            @(negedge core_clk);
            n++;
            w = avs_waitrequest;
            q = avs_readdata;
            @(posedge core_clk);
        end while (w !== 1'b0 && n < 50);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            final_report();
        end
    endtask

    // Runs the counter from zero with a clock select code for a number of cycles.
    task automatic run(input logic [7:0] ctl, input int cyc);
        bus(1'b1, 5'h04, 8'h00);
        bus(1'b1, 5'h0C, 8'h03);
        bus(1'b1, 5'h00, ctl);
        repeat (cyc) @(posedge core_clk);
        bus(1'b1, 5'h00, ctl & 8'hF8);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 5'(i * 4), 8'h00);
            chk(q, 32'h0);
        end
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 8'h00);
            chk(q, {24'h0, rows[i].e});
        end
        $display("test register table done");
        bus(1'b1, 5'h04, 8'h10);
        repeat (20) @(posedge core_clk);
        bus(1'b0, 5'h04, 8'h00);
        chk(q, 32'h10);
        for (int i = 0; i < 2; i++) begin
            run(8'(rng[i][0]), rng[i][1]);
            bus(1'b0, 5'h04, 8'h00);
            chk(32'(q >= rng[i][2] && q <= rng[i][3]), 32'h1);
        end
        for (int c = 7; c >= 6; c--) begin
            run(8'(c), 0);
            bus(1'b1, 5'h00, 8'(c));
            repeat (3) begin
                ext_count_pin <= 1'b1;
                repeat (4) @(posedge core_clk);
                ext_count_pin <= 1'b0;
                repeat (4) @(posedge core_clk);
            end
            repeat (8) @(posedge core_clk);
            bus(1'b0, 5'h04, 8'h00);
            chk(q, 32'h3);
            bus(1'b1, 5'h00, 8'h00);
        end
        $display("test clock sources done");
        bus(1'b1, 5'h08, 8'h20);
        bus(1'b1, 5'h10, 8'h02);
        service_en <= 1'b1;
        run(8'h01, 60);
        bus(1'b0, 5'h0C, 8'h00);
        chk(q, 32'h2);
        chk(cmp_irq, 1'b0);
        global_irq_enable <= 1'b1;
        @(posedge core_clk);
        @(posedge core_clk);
        chk(cmp_irq, 1'b1);
        for (int n = 0; n < 20 && cmp_irq === 1'b1; n++) @(posedge core_clk);
        chk(cmp_irq, 1'b0);
        bus(1'b0, 5'h0C, 8'h00);
        chk(q, 32'h0);
        service_en <= 1'b0;
        bus(1'b1, 5'h10, 8'h03);
        bus(1'b1, 5'h0C, 8'h03);
        bus(1'b1, 5'h04, 8'hFE);
        bus(1'b1, 5'h00, 8'h01);
        repeat (10) @(posedge core_clk);
        bus(1'b1, 5'h00, 8'h00);
        chk(ovf_irq, 1'b1);
        bus(1'b1, 5'h0C, 8'h01);
        bus(1'b0, 5'h0C, 8'h00);
        chk(q & 32'h1, 32'h0);
        $display("test flags and interrupts done");
        bus(1'b1, 5'h08, 8'h40);
        bus(1'b1, 5'h04, 8'h40);
        bus(1'b1, 5'h0C, 8'h03);
        bus(1'b1, 5'h00, 8'h01);
        repeat (5) @(posedge core_clk);
        bus(1'b1, 5'h00, 8'h00);
        bus(1'b0, 5'h0C, 8'h00);
        chk(q & 32'h2, 32'h0);
        bus(1'b1, 5'h08, 8'h08);
        run(8'h11, 40);
        bus(1'b0, 5'h0C, 8'h00);
        chk(q, 32'h2);
        bus(1'b0, 5'h04, 8'h00);
        chk(32'(q <= 32'h8), 32'h1);
        $display("test match block and clear on match done");
        bus(1'b1, 5'h04, 8'h20);
        bus(1'b1, 5'h0C, 8'h03);
        // Output is set up by a forced compare in normal mode before it is used.
        bus(1'b1, 5'h00, 8'h60);
        bus(1'b1, 5'h14, 8'h01);
        @(posedge core_clk);
        chk(compare_output, 1'b1);
        bus(1'b0, 5'h0C, 8'h00);
        chk(q, 32'h0);
        bus(1'b0, 5'h04, 8'h00);
        chk(q, 32'h20);
        bus(1'b1, 5'h00, 8'h40);
        bus(1'b1, 5'h14, 8'h01);
        @(posedge core_clk);
        chk(compare_output, 1'b0);
        bus(1'b1, 5'h00, 8'h20);
        bus(1'b1, 5'h14, 8'h01);
        bus(1'b1, 5'h08, 8'h10);
        bus(1'b1, 5'h00, 8'h58);
        chk(compare_output, 1'b1);
        bus(1'b1, 5'h14, 8'h01);
        @(posedge core_clk);
        chk(compare_output, 1'b1);
        bus(1'b1, 5'h08, 8'hC0);
        bus(1'b0, 5'h08, 8'h00);
        chk(q, 32'hC0);
        // The counter starts below the old compare value and stops well before top.
        bus(1'b1, 5'h04, 8'h05);
        bus(1'b1, 5'h0C, 8'h03);
        bus(1'b1, 5'h00, 8'h59);
        repeat (30) @(posedge core_clk);
        bus(1'b1, 5'h00, 8'h58);
        bus(1'b0, 5'h0C, 8'h00);
        chk(q & 32'h2, 32'h2);
        chk(compare_output, 1'b0);
        $display("test force and buffering done");
        final_report();
    end
endmodule

// File: dv/tcu_cpu_model.sv
// Model of the core that services the timer interrupts.
`timescale 1ns/1ps

// ****************************************************************
// Interrupt service model.
// ****************************************************************
module tcu_cpu_model #(
    parameter int LAT = 3   // Cycles counted before service; the ack rises LAT+1 cycles after the request; larger values model a slow core.
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic service_en,
    input  wire logic overflow_irq,
    input  wire logic compare_irq,
    output logic      overflow_irq_ack,
    output logic      compare_irq_ack
);
    int cnt;   // Service latency counter.

    // One ack pulse per request; the guard stops a second ack before the flag falls.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt              <= 0;
            overflow_irq_ack <= 1'b0;
            compare_irq_ack  <= 1'b0;
        end else begin
            overflow_irq_ack <= 1'b0;
            compare_irq_ack  <= 1'b0;
            if (service_en && (overflow_irq || compare_irq) &&
                !(overflow_irq_ack || compare_irq_ack)) begin
                if (cnt >= LAT) begin
                    cnt              <= 0;
                    overflow_irq_ack <= overflow_irq;
                    compare_irq_ack  <= compare_irq && !overflow_irq;
                end else begin
                    cnt <= cnt + 1;
                end
            end else begin
                cnt <= 0;
            end
        end
    end
endmodule

// File: logic/tcu_cfg.svh
// Register offsets, field positions, reset values and timing counts of the timer compare unit.
`ifndef TCU_CFG_SVH
`define TCU_CFG_SVH

// ****************************************************************
// Register byte offsets on the Avalon-MM slave.
// ****************************************************************
`define TCU_OFS_CONTROL 4'h0
`define TCU_OFS_COUNT   4'h4
`define TCU_OFS_COMPARE 4'h8
`define TCU_OFS_FLAG    4'hC
`define TCU_OFS_MASK    5'h10
`define TCU_OFS_FORCE   5'h14

// ****************************************************************
// Field positions in the control and flag registers.
// ****************************************************************
`define TCU_CTL_CS_LSB   0
`define TCU_CTL_WGM_LSB  3
`define TCU_CTL_COM_LSB  5
`define TCU_FLG_OVF_BIT  0
`define TCU_FLG_CMP_BIT  1

// ****************************************************************
// Values and reset values.
// ****************************************************************
`define TCU_BOTTOM       8'h00
`define TCU_MAX          8'hFF
`define TCU_RST_BYTE     8'h00

// ****************************************************************
// Prescaler terminal counts, one less than each divisor in system clock cycles.
// ****************************************************************
`define TCU_DIV_8        10'h007
`define TCU_DIV_64       10'h03F
`define TCU_DIV_256      10'h0FF
`define TCU_DIV_1024     10'h3FF

`endif

// File: logic/tcu_pkg.sv
// Types shared by the timer compare unit.
package tcu_pkg;

    // Waveform modes; code 1 is not offered by this unit and behaves as normal.
    typedef enum logic [1:0] {
        TCU_WGM_NORMAL = 2'b00,
        TCU_WGM_RSVD   = 2'b01,
        TCU_WGM_CTC    = 2'b10,
        TCU_WGM_FPWM   = 2'b11
    } tcu_wgm_t;

    // Clock select codes.
    typedef enum logic [2:0] {
        TCU_CS_STOP  = 3'b000,
        TCU_CS_DIV1  = 3'b001,
        TCU_CS_DIV8  = 3'b010,
        TCU_CS_DIV64 = 3'b011,
        TCU_CS_D256  = 3'b100,
        TCU_CS_D1024 = 3'b101,
        TCU_CS_EXTF  = 3'b110,
        TCU_CS_EXTR  = 3'b111
    } tcu_cs_t;

    // Whole state of the unit.
    typedef struct packed {
        logic [2:0] clock_select_field;   // Tick source.
        tcu_wgm_t   waveform_mode_field;  // Count sequence.
        logic [1:0] output_action_field;  // Compare output action.
        logic [7:0] count_value;          // Counter.
        logic [7:0] compare_value;        // Active compare register.
        logic [7:0] compare_buf;          // Buffered compare value.
        logic       overflow_flag;        // Sticky overflow.
        logic       compare_flag;         // Sticky compare.
        logic [1:0] irq_mask;             // Interrupt mask bits.
        logic       compare_output;       // Compare output register.
        logic       block_match;          // Match suppression after a count write.
        logic [9:0] presc;                // Free running prescaler.
        logic       ext_s1;               // Pin synchroniser first stage.
        logic       ext_s2;               // Pin synchroniser second stage.
        logic       ext_s3;               // Edge detector history.
        logic [7:0] rdata;                // Read data.
        logic       ack;                  // Answer strobe.
    } tcu_state_t;

endpackage

// File: logic/tcu_timer.sv
// Eight-bit timer/counter with one output compare channel and an Avalon-MM slave.
`timescale 1ns/1ps
`include "tcu_cfg.svh"

module tcu_timer (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_count_pin,
    input  wire logic        global_irq_enable,
    input  wire logic        overflow_irq_ack,
    input  wire logic        compare_irq_ack,
    output logic             overflow_irq,
    output logic             compare_irq,
    output logic             compare_output
);

    // ****************************************************************
    // State registers.
    // ****************************************************************
    tcu_pkg::tcu_state_t st_q;   // Registered state.
    tcu_pkg::tcu_state_t st_d;   // Next state.

    // Combinational decode shared by the next-state logic and the checks.
    logic       tick;            // Timer tick this cycle.
    logic       buffered;        // Compare double buffering active.
    logic [7:0] top_val;         // Highest value of the sequence.
    logic       at_top;          // Counter at top.
    logic       at_bottom;       // Counter at bottom.
    logic       at_max;          // Counter at max.
    logic       match;           // Unblocked compare match.
    logic       wr_cnt;          // Bus write to the counter.
    logic       wr_en;           // Bus write taken in this cycle.
    logic       acc;             // Bus access this cycle.

    // ****************************************************************
    // Tick selection and decode.
    // ****************************************************************
    // The pin edge detector looks only at the second and third stages.
    always_comb begin
        unique case (tcu_pkg::tcu_cs_t'(st_q.clock_select_field))
            tcu_pkg::TCU_CS_STOP:  tick = 1'b0;
            tcu_pkg::TCU_CS_DIV1:  tick = 1'b1;
            tcu_pkg::TCU_CS_DIV8:  tick = (st_q.presc[2:0] == `TCU_DIV_8);
            tcu_pkg::TCU_CS_DIV64: tick = (st_q.presc[5:0] == `TCU_DIV_64);
            tcu_pkg::TCU_CS_D256:  tick = (st_q.presc[7:0] == `TCU_DIV_256);
            tcu_pkg::TCU_CS_D1024: tick = (st_q.presc == `TCU_DIV_1024);
            tcu_pkg::TCU_CS_EXTF:  tick = st_q.ext_s3 & ~st_q.ext_s2;
            tcu_pkg::TCU_CS_EXTR:  tick = ~st_q.ext_s3 & st_q.ext_s2;
        endcase
    end

    // Mode decode, extreme values and the comparator.
    always_comb begin
        buffered  = (st_q.waveform_mode_field == tcu_pkg::TCU_WGM_FPWM);
        top_val   = (st_q.waveform_mode_field == tcu_pkg::TCU_WGM_CTC)
                    ? st_q.compare_value : `TCU_MAX;
        at_top    = (st_q.count_value == top_val);
        at_bottom = (st_q.count_value == `TCU_BOTTOM);
        at_max    = (st_q.count_value == `TCU_MAX);
        match     = (st_q.count_value == st_q.compare_value) & ~st_q.block_match;
        acc       = avs_read | avs_write;
        // A write is taken only in its answer cycle, so a waited request acts once.
        wr_en     = avs_write & st_q.ack;
        wr_cnt    = wr_en & (avs_address == 5'(`TCU_OFS_COUNT));
    end

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    // Every effect of a tick is qualified by tick, so a stopped timer
    // keeps its state while the bus still reaches every register.
    always_comb begin
        st_d = st_q;
        st_d.ack = 1'b0;
        st_d.presc = st_q.presc + 10'h001;
        st_d.ext_s1 = ext_count_pin;
        st_d.ext_s2 = st_q.ext_s1;
        st_d.ext_s3 = st_q.ext_s2;

        // Counting: wrap from top to bottom, otherwise increment.
        if (tick) begin
            if (at_top) begin
                st_d.count_value = `TCU_BOTTOM;
            end else begin
                st_d.count_value = st_q.count_value + 8'h01;
            end
            // The block lasts exactly one tick after a counter write.
            st_d.block_match = 1'b0;
            // Overflow when the counter passes max to bottom in every mode.
            if (at_max) begin
                st_d.overflow_flag = 1'b1;
            end
            // Match raises the flag at this following tick.
            if (match) begin
                st_d.compare_flag = 1'b1;
            end
            // Buffered compare value is taken over at top.
            if (buffered && at_top) begin
                st_d.compare_value = st_q.compare_buf;
            end
            // Waveform generator: match and top decide the output.
            unique case (st_q.waveform_mode_field)
                tcu_pkg::TCU_WGM_FPWM: begin
                    if (match && st_q.output_action_field[1]) begin
                        st_d.compare_output = st_q.output_action_field[0];
                    end else if (at_top && st_q.output_action_field[1]) begin
                        st_d.compare_output = ~st_q.output_action_field[0];
                    end
                end
                default: begin
                    if (match) begin
                        unique case (st_q.output_action_field)
                            2'b01:   st_d.compare_output = ~st_q.compare_output;
                            2'b10:   st_d.compare_output = 1'b0;
                            2'b11:   st_d.compare_output = 1'b1;
                            default: st_d.compare_output = st_q.compare_output;
                        endcase
                    end
                end
            endcase
        end

        // Interrupt service clears the flags, but a same-cycle set wins.
        if (overflow_irq_ack && !(tick && at_max)) begin
            st_d.overflow_flag = 1'b0;
        end
        if (compare_irq_ack && !(tick && match)) begin
            st_d.compare_flag = 1'b0;
        end

        // Bus writes; a counter write overrides count and clear.
        if (wr_en) begin
            unique case (avs_address)
                5'(`TCU_OFS_CONTROL): begin
                    st_d.clock_select_field  = avs_writedata[`TCU_CTL_CS_LSB +: 3];
                    st_d.waveform_mode_field =
                        tcu_pkg::tcu_wgm_t'(avs_writedata[`TCU_CTL_WGM_LSB +: 2]);
                    st_d.output_action_field = avs_writedata[`TCU_CTL_COM_LSB +: 2];
                    // The output register is left as it is.
                end
                5'(`TCU_OFS_COUNT): begin
                    st_d.count_value = avs_writedata[7:0];
                    st_d.block_match = 1'b1;
                end
                5'(`TCU_OFS_COMPARE): begin
                    if (buffered) begin
                        st_d.compare_buf = avs_writedata[7:0];
                    end else begin
                        st_d.compare_value = avs_writedata[7:0];
                        st_d.compare_buf   = avs_writedata[7:0];
                    end
                end
                5'(`TCU_OFS_FLAG): begin
                    if (avs_writedata[`TCU_FLG_OVF_BIT] && !(tick && at_max)) begin
                        st_d.overflow_flag = 1'b0;
                    end
                    if (avs_writedata[`TCU_FLG_CMP_BIT] && !(tick && match)) begin
                        st_d.compare_flag = 1'b0;
                    end
                end
                5'(`TCU_OFS_MASK): begin
                    st_d.irq_mask = avs_writedata[1:0];
                end
                5'(`TCU_OFS_FORCE): begin
                    // Forced match moves the output only; no flag, no clear.
                    if (avs_writedata[0] && !buffered) begin
                        unique case (st_q.output_action_field)
                            2'b01:   st_d.compare_output = ~st_q.compare_output;
                            2'b10:   st_d.compare_output = 1'b0;
                            2'b11:   st_d.compare_output = 1'b1;
                            default: st_d.compare_output = st_d.compare_output;
                        endcase
                    end
                end
                default: begin
                    st_d.ack = st_q.ack & 1'b0;
                end
            endcase
        end

        // Read data; unmapped addresses answer zero.
        unique case (avs_address)
            5'(`TCU_OFS_CONTROL): st_d.rdata = {1'b0, st_q.output_action_field,
                                                st_q.waveform_mode_field,
                                                st_q.clock_select_field};
            5'(`TCU_OFS_COUNT):   st_d.rdata = st_q.count_value;
            5'(`TCU_OFS_COMPARE): st_d.rdata = buffered ? st_q.compare_buf
                                                        : st_q.compare_value;
            5'(`TCU_OFS_FLAG):    st_d.rdata = {6'h00, st_q.compare_flag,
                                                st_q.overflow_flag};
            5'(`TCU_OFS_MASK):    st_d.rdata = {6'h00, st_q.irq_mask};
            default:              st_d.rdata = `TCU_RST_BYTE;
        endcase

        // One-cycle wait then answer; the write above was taken at the answer edge.
        st_d.ack = acc & ~st_q.ack;
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // Writes are committed only at the answer edge, guarded below.
    always_comb begin
        avs_waitrequest = acc & ~st_q.ack;
        avs_readdata    = {24'h000000, st_q.rdata};
        overflow_irq    = st_q.overflow_flag & st_q.irq_mask[0] & global_irq_enable;
        compare_irq     = st_q.compare_flag & st_q.irq_mask[1] & global_irq_enable;
        compare_output  = st_q.compare_output;
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    // A stopped timer keeps its count unless written.
    property p_stop_holds;
        @(posedge core_clk) disable iff (!resetn)
        (st_q.clock_select_field == 3'h0 && !avs_write) |=> $stable(st_q.count_value);
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

    // A taken counter write lands whatever the tick does.
    property p_write_wins;
        @(posedge core_clk) disable iff (!resetn)
        wr_cnt |=> (st_q.count_value == $past(avs_writedata[7:0]));
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("counter write lost");

    // A counter write and then a tick leave the flag alone.
    sequence s_cnt_write;
        wr_cnt && !compare_irq_ack && !(avs_write && avs_address == 5'h0C);
    endsequence

    sequence s_next_tick;
        tick && !compare_irq_ack;
    endsequence

    property p_block;
        @(posedge core_clk) disable iff (!resetn)
        s_cnt_write ##1 s_next_tick |=> $stable(st_q.compare_flag);
    endproperty
    a_block: assert property (p_block) else $error("match not blocked after write");

    // A ticked match always sets the compare flag.
    property p_cmp_flag;
        @(posedge core_clk) disable iff (!resetn)
        (tick && match) |=> st_q.compare_flag;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");

    // Passing max lands on bottom with overflow set.
    property p_ovf;
        @(posedge core_clk) disable iff (!resetn)
        (tick && at_max && !wr_cnt) |=> (st_q.overflow_flag && at_bottom);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not set at wrap");

    // Clear on match returns to bottom after top.
    property p_ctc_clear;
        @(posedge core_clk) disable iff (!resetn)
        (tick && !avs_write && st_q.waveform_mode_field == tcu_pkg::TCU_WGM_CTC
         && st_q.count_value == st_q.compare_value) |=> (st_q.count_value == 8'h00);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on match");

    // The request never stands without both enables.
    property p_irq;
        @(posedge core_clk) disable iff (!resetn)
        compare_irq |-> (global_irq_enable && st_q.irq_mask[1] && st_q.compare_flag);
    endproperty
    a_irq: assert property (p_irq) else $error("compare irq without enables");

    // Off top the active compare moves only by a write.
    property p_buf_hold;
        @(posedge core_clk) disable iff (!resetn)
        (buffered && !(tick && at_top) && !avs_write) |=> $stable(st_q.compare_value);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("active compare changed off top");

    // Every access waits exactly one cycle.
    property p_ack;
        @(posedge core_clk) disable iff (!resetn)
        (acc && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");

    // A waited write to the mask register commits nothing.
    property p_wait_no_write;
        @(posedge core_clk) disable iff (!resetn)
        (avs_write && avs_waitrequest && avs_address == 5'(`TCU_OFS_MASK))
            |=> $stable(st_q.irq_mask);
    endproperty
    a_wait_no_write: assert property (p_wait_no_write) else $error("waited write taken");

    // Compare writes go to buffer or active register.
    property p_cmp_route;
        @(posedge core_clk) disable iff (!resetn)
        (wr_en && avs_address == 5'(`TCU_OFS_COMPARE))
            |=> (($past(buffered) ? st_q.compare_buf : st_q.compare_value)
                 == $past(avs_writedata[7:0]));
    endproperty
    a_cmp_route: assert property (p_cmp_route) else $error("compare write misrouted");

    // A forced set or clear drives the output at once.
    property p_force_out;
        @(posedge core_clk) disable iff (!resetn)
        (wr_en && avs_address == 5'(`TCU_OFS_FORCE) && avs_writedata[0] && !buffered
         && st_q.output_action_field[1])
            |=> (st_q.compare_output == $past(st_q.output_action_field[0]));
    endproperty
    a_force_out: assert property (p_force_out) else $error("forced compare ignored");

    // A forced compare leaves flag and counter alone.
    property p_force_quiet;
        @(posedge core_clk) disable iff (!resetn)
        (wr_en && avs_address == 5'(`TCU_OFS_FORCE) && !tick && !compare_irq_ack)
            |=> ($stable(st_q.compare_flag) && $stable(st_q.count_value));
    endproperty
    a_force_quiet: assert property (p_force_quiet) else $error("force had side effects");

    // Control writes never move the output register.
    property p_keep_out;
        @(posedge core_clk) disable iff (!resetn)
        (wr_en && avs_address == 5'(`TCU_OFS_CONTROL) && !tick) |=> $stable(st_q.compare_output);
    endproperty
    a_keep_out: assert property (p_keep_out) else $error("mode change moved output");

endmodule
